//--- rtl/pbi_pkg.sv
// Purpose: Shared constants and helpers for the pulse/binary input unit
// Assumes: 250 MHz system clock, eight inputs
// Notes: Long cycle counts are defaults of top-level parameters
package pbi_pkg;
    localparam int NUM_IN = 8;
    localparam int IDX_W = 3;
    localparam int CNT_W = 32;
    localparam int TIME_W = 32;
    localparam int WEIGHT_W = 16;
    localparam int FLOW_W = 16;
    localparam int PROD_W = CNT_W + WEIGHT_W;

    // Timing
    localparam int CLK_NS = 4;
    localparam int MIN_PULSE_NS = 2_000_000;
    localparam int MIN_PULSE_CYC = MIN_PULSE_NS / CLK_NS;
    localparam int DEB_CYC = MIN_PULSE_CYC / 2;
    localparam int SEC_NS = 1_000_000_000;
    localparam int SEC_CYC = SEC_NS / CLK_NS;

    // Reset values
    localparam logic PIN_IDLE = 1'b1;
    localparam logic [CNT_W-1:0] CNT_RST = 32'h0000_0000;
    localparam logic [TIME_W-1:0] TIME_RST = 32'h0000_0000;

    typedef enum logic {ST_IDLE, ST_WALK} pbi_store_t;

    // Lowest set bit: {found, index}
    function automatic logic [IDX_W:0] pbi_first_set(input logic [NUM_IN-1:0] v);
        logic [IDX_W:0] r;
        r = '0;
        for (int i = NUM_IN - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = {1'b1, IDX_W'(i)};
            end
        end
        return r;
    endfunction

    // Count times weight
    function automatic logic [PROD_W-1:0] pbi_weigh(input logic [CNT_W-1:0] c,
                                                    input logic [WEIGHT_W-1:0] w);
        pbi_weigh = PROD_W'(c) * PROD_W'(w);
    endfunction
endpackage

//--- rtl/pbi_debounce.sv
// Purpose: Synchronise and debounce one input pin
// Assumes: Pin is asynchronous to clock
// Notes: Level changes only after HOLD stable cycles
`timescale 1ns/10ps
module pbi_debounce #(
    parameter int HOLD = pbi_pkg::DEB_CYC // Stable cycles needed
) (
    input wire logic clock, // System clock
    input wire logic rst, // Async reset, active high
    input wire logic clk_en, // Freezes state when low
    input wire logic pin_raw, // Raw pin level
    output logic level // Debounced pin level
);
    import pbi_pkg::*;
    localparam int CW = $clog2(HOLD + 1);

    default clocking @(posedge clock); endclocking
    default disable iff (rst);

    logic sync1;
    logic sync2;
    logic [CW-1:0] cnt;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sync1 <= PIN_IDLE;
            sync2 <= PIN_IDLE;
        end else if (clk_en) begin
            sync1 <= pin_raw;
            sync2 <= sync1;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            level <= PIN_IDLE;
            cnt <= '0;
        end else if (clk_en) begin
            if (sync2 == level) begin
                cnt <= '0;
            end else if (cnt == CW'(HOLD - 1)) begin
                level <= sync2;
                cnt <= '0;
            end else begin
                cnt <= cnt + 1'b1;
            end
        end
    end

    chk_deb_hold: assert property (clk_en && sync2 != level && cnt != CW'(HOLD - 1)
        |=> $stable(level)) else $error("debounced level changed early");
endmodule

//--- rtl/pbi_unit.sv
// Purpose: Eight pulse/binary inputs with events, alarms, timers, counters
// Assumes: Contacts pull pins low; one 250 MHz clock
// Notes: Config and status are plain ports; outputs are registered
`timescale 1ns/10ps

//
// Behaviour
// - Each input is set independently to binary or pulse operation.
// - Binary mode reports every transition, open-to-closed and closed-to-open.
// - Pulse mode adds one to the input's counter per detected pulse.
// - Idle pin is high; grounding the pin makes the input active.
// - Pulses of at least two milliseconds are always counted.
// - Each pulse counter is 32 bits wide, over four billion counts.
// - Each storing interval, raw or weighted count is recorded per pulse input.
// - Binary change warns, optionally only after continuous activity for preset time.
// - Every binary state change is logged with its time in seconds.
// - One indicator output per input shows its switched state.
// - Pulse inputs give instantaneous flow from weight and pulse frequency.
// - Total switched time of each binary input is accumulated.
// - An input works only while a measurement channel is assigned to it.
// - In economy operation pulse counting, storing and indicators continue; binary functions and flow stop.
module pbi_unit #(
    parameter int DEB_CYCLES = pbi_pkg::DEB_CYC, // Debounce hold cycles
    parameter int SEC_CYCLES = pbi_pkg::SEC_CYC // Cycles per second
) (
    input wire logic clock, // System clock
    input wire logic rst, // Async reset, active high
    input wire logic clk_en, // Freezes all state when low
    input wire logic [pbi_pkg::NUM_IN-1:0] pin_n, // Input pins, low = active
    input wire logic [pbi_pkg::NUM_IN-1:0] mode_pulse, // 1 pulse, 0 binary
    input wire logic [pbi_pkg::NUM_IN-1:0] chan_assigned, // Channel assigned
    input wire logic [pbi_pkg::NUM_IN-1:0] alarm_delay_en, // Delayed warning
    input wire logic economy, // Economy operation
    input wire logic [pbi_pkg::TIME_W-1:0] alarm_delay, // Warning delay, s
    input wire logic [pbi_pkg::WEIGHT_W-1:0] pulse_weight, // Weight per pulse
    input wire logic [pbi_pkg::TIME_W-1:0] store_interval, // Storing interval, s
    input wire logic store_weighted, // Record weighted count
    input wire logic time_load, // Load clock time
    input wire logic [pbi_pkg::TIME_W-1:0] time_set, // Time to load, s
    input wire logic [pbi_pkg::IDX_W-1:0] rd_sel, // Readout input select
    output logic [pbi_pkg::NUM_IN-1:0] input_state_indicators, // Switched state
    output logic event_valid, // Event log pulse
    output logic [pbi_pkg::IDX_W-1:0] event_input, // Event input index
    output logic event_level, // New state, 1 = closed
    output logic [pbi_pkg::TIME_W-1:0] event_time, // Time of change, s
    output logic warn_valid, // Warning pulse
    output logic [pbi_pkg::IDX_W-1:0] warn_input, // Warning input index
    output logic store_valid, // Record pulse
    output logic [pbi_pkg::IDX_W-1:0] store_input, // Record input index
    output logic [pbi_pkg::PROD_W-1:0] store_value, // Recorded value
    output logic [pbi_pkg::CNT_W-1:0] rd_count, // Pulse count of rd_sel
    output logic [pbi_pkg::TIME_W-1:0] rd_active_sec, // Active seconds of rd_sel
    output logic [pbi_pkg::PROD_W-1:0] rd_flow // Flow of rd_sel per second
);
    import pbi_pkg::*;
    localparam int SW = $clog2(SEC_CYCLES + 1);

    default clocking @(posedge clock); endclocking
    default disable iff (rst);

    // ----------------------------------------
    // Input conditioning
    // ----------------------------------------
    logic [NUM_IN-1:0] deb_level;
    logic [NUM_IN-1:0] act;
    logic [NUM_IN-1:0] act_prev;
    logic [NUM_IN-1:0] rise;
    logic [NUM_IN-1:0] edge_det;
    logic [NUM_IN-1:0] bin_en;
    logic [NUM_IN-1:0] pul_en;

    for (genvar g = 0; g < NUM_IN; g++) begin : g_deb
        pbi_debounce #(.HOLD(DEB_CYCLES)) u_deb (
            .clock(clock),
            .rst(rst),
            .clk_en(clk_en),
            .pin_raw(pin_n[g]),
            .level(deb_level[g])
        );
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            act <= '0;
            act_prev <= '0;
        end else if (clk_en) begin
            act <= ~deb_level;
            act_prev <= act;
        end
    end

    assign rise = act & ~act_prev;
    assign edge_det = act ^ act_prev;
    assign bin_en = chan_assigned & ~mode_pulse & {NUM_IN{~economy}};
    assign pul_en = chan_assigned & mode_pulse;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            input_state_indicators <= '0;
        end else if (clk_en) begin
            input_state_indicators <= act & chan_assigned;
        end
    end

    // ----------------------------------------
    // Seconds base and clock time
    // ----------------------------------------
    logic [SW-1:0] sec_div;
    logic sec_tick;
    logic [TIME_W-1:0] time_now;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sec_div <= '0;
            sec_tick <= 1'b0;
            time_now <= TIME_RST;
        end else if (clk_en) begin
            sec_tick <= (sec_div == SW'(SEC_CYCLES - 1));
            sec_div <= (sec_div == SW'(SEC_CYCLES - 1)) ? '0 : sec_div + 1'b1;
            if (time_load) begin
                time_now <= time_set;
            end else if (sec_tick) begin
                time_now <= time_now + 1'b1;
            end
        end
    end

    // ----------------------------------------
    // Pulse counters and flow window
    // ----------------------------------------
    logic [CNT_W-1:0] pulse_cnt [NUM_IN];
    logic [FLOW_W-1:0] win_cnt [NUM_IN];
    logic [FLOW_W-1:0] flow_lat [NUM_IN];

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < NUM_IN; i++) begin
                pulse_cnt[i] <= CNT_RST;
            end
        end else if (clk_en) begin
            for (int i = 0; i < NUM_IN; i++) begin
                if (pul_en[i] && rise[i]) begin
                    pulse_cnt[i] <= pulse_cnt[i] + 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < NUM_IN; i++) begin
                win_cnt[i] <= '0;
                flow_lat[i] <= '0;
            end
        end else if (clk_en) begin
            for (int i = 0; i < NUM_IN; i++) begin
                if (!pul_en[i] || economy) begin
                    win_cnt[i] <= '0;
                end else if (sec_tick) begin
                    flow_lat[i] <= win_cnt[i];
                    win_cnt[i] <= FLOW_W'(rise[i]);
                end else if (rise[i] && win_cnt[i] != '1) begin
                    win_cnt[i] <= win_cnt[i] + 1'b1;
                end
            end
        end
    end

    // ----------------------------------------
    // Binary events, alarms, active time
    // ----------------------------------------
    logic [NUM_IN-1:0] ev_pend;
    logic [NUM_IN-1:0] ev_lvl;
    logic [TIME_W-1:0] ev_time [NUM_IN];
    logic [IDX_W:0] ev_pick;
    logic [NUM_IN-1:0] ev_clr;
    logic [NUM_IN-1:0] warn_pend;
    logic [NUM_IN-1:0] warn_set;
    logic [NUM_IN-1:0] warn_done;
    logic [IDX_W:0] warn_pick;
    logic [NUM_IN-1:0] warn_clr;
    logic [TIME_W-1:0] hold_sec [NUM_IN];
    logic [TIME_W-1:0] act_sec [NUM_IN];

    assign ev_pick = pbi_first_set(ev_pend);
    assign ev_clr = ev_pick[IDX_W] ? NUM_IN'(1) << ev_pick[IDX_W-1:0] : '0;
    assign warn_pick = pbi_first_set(warn_pend);
    assign warn_clr = warn_pick[IDX_W] ? NUM_IN'(1) << warn_pick[IDX_W-1:0] : '0;

    always_comb begin
        for (int i = 0; i < NUM_IN; i++) begin
            if (alarm_delay_en[i]) begin
                warn_set[i] = bin_en[i] && act[i] && !warn_done[i]
                              && hold_sec[i] >= alarm_delay;
            end else begin
                warn_set[i] = bin_en[i] && edge_det[i];
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ev_pend <= '0;
            ev_lvl <= '0;
            for (int i = 0; i < NUM_IN; i++) begin
                ev_time[i] <= TIME_RST;
            end
        end else if (clk_en) begin
            // New change wins over the clear
            ev_pend <= (ev_pend & ~ev_clr) | (edge_det & bin_en);
            for (int i = 0; i < NUM_IN; i++) begin
                if (edge_det[i] && bin_en[i]) begin
                    ev_lvl[i] <= act[i];
                    ev_time[i] <= time_now;
                end
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            event_valid <= 1'b0;
            event_input <= '0;
            event_level <= 1'b0;
            event_time <= TIME_RST;
        end else if (clk_en) begin
            event_valid <= ev_pick[IDX_W];
            event_input <= ev_pick[IDX_W-1:0];
            event_level <= ev_lvl[ev_pick[IDX_W-1:0]];
            event_time <= ev_time[ev_pick[IDX_W-1:0]];
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            warn_pend <= '0;
            warn_done <= '0;
            warn_valid <= 1'b0;
            warn_input <= '0;
            for (int i = 0; i < NUM_IN; i++) begin
                hold_sec[i] <= TIME_RST;
            end
        end else if (clk_en) begin
            warn_pend <= (warn_pend & ~warn_clr) | warn_set;
            warn_done <= (warn_done | warn_set) & act & bin_en;
            warn_valid <= warn_pick[IDX_W];
            warn_input <= warn_pick[IDX_W-1:0];
            for (int i = 0; i < NUM_IN; i++) begin
                if (!(act[i] && bin_en[i])) begin
                    hold_sec[i] <= TIME_RST;
                end else if (sec_tick && hold_sec[i] != '1) begin
                    hold_sec[i] <= hold_sec[i] + 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < NUM_IN; i++) begin
                act_sec[i] <= TIME_RST;
            end
        end else if (clk_en) begin
            for (int i = 0; i < NUM_IN; i++) begin
                if (sec_tick && act[i] && bin_en[i]) begin
                    act_sec[i] <= act_sec[i] + 1'b1;
                end
            end
        end
    end

    // ----------------------------------------
    // Interval storing
    // ----------------------------------------
    pbi_store_t st_state;
    logic [TIME_W-1:0] st_sec;
    logic [IDX_W-1:0] st_idx;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            st_state <= ST_IDLE;
            st_sec <= TIME_RST;
            st_idx <= '0;
            store_valid <= 1'b0;
            store_input <= '0;
            store_value <= '0;
        end else if (clk_en) begin
            store_valid <= 1'b0;
            case (st_state)
                ST_IDLE: begin
                    if (store_interval == '0) begin
                        st_sec <= TIME_RST;
                    end else if (sec_tick) begin
                        if (st_sec + 1'b1 >= store_interval) begin
                            st_sec <= TIME_RST;
                            st_idx <= '0;
                            st_state <= ST_WALK;
                        end else begin
                            st_sec <= st_sec + 1'b1;
                        end
                    end
                end
                ST_WALK: begin
                    store_valid <= pul_en[st_idx];
                    store_input <= st_idx;
                    store_value <= store_weighted ? pbi_weigh(pulse_cnt[st_idx], pulse_weight)
                                                  : PROD_W'(pulse_cnt[st_idx]);
                    st_idx <= st_idx + 1'b1;
                    if (st_idx == IDX_W'(NUM_IN - 1)) begin
                        st_state <= ST_IDLE;
                    end
                end
                default: begin
                    st_state <= ST_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------
    // Readout
    // ----------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rd_count <= CNT_RST;
            rd_active_sec <= TIME_RST;
            rd_flow <= '0;
        end else if (clk_en) begin
            rd_count <= pulse_cnt[rd_sel];
            rd_active_sec <= act_sec[rd_sel];
            rd_flow <= pbi_weigh(CNT_W'(flow_lat[rd_sel]), pulse_weight);
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    chk_mode_binary: assert property (clk_en && !mode_pulse[0]
        |=> $stable(pulse_cnt[0])) else $error("binary input counted");
    chk_edge_logged: assert property (clk_en && bin_en[0] && edge_det[0]
        |=> ev_pend[0] && ev_lvl[0] == $past(act[0])) else $error("change not logged");
    chk_count_inc: assert property (clk_en && pul_en[0] && rise[0]
        |=> pulse_cnt[0] == $past(pulse_cnt[0]) + 1'b1) else $error("pulse not counted");
    chk_store_value: assert property (clk_en && st_state == ST_WALK && st_idx == '0
        |=> store_input == '0 && store_valid == $past(pul_en[0])
            && store_value == $past(store_weighted ? pbi_weigh(pulse_cnt[0], pulse_weight)
                                                   : PROD_W'(pulse_cnt[0])))
        else $error("wrong stored value");
    chk_warn_delay: assert property (clk_en && alarm_delay_en[0]
        && hold_sec[0] < alarm_delay |-> !warn_set[0]) else $error("early warning");
    chk_event_time: assert property (clk_en && ev_pick == {1'b1, IDX_W'(0)}
        |=> event_valid && event_input == '0 && event_time == $past(ev_time[0]))
        else $error("event time wrong");
    chk_indicator: assert property (clk_en
        |=> input_state_indicators == $past(act & chan_assigned)) else $error("bad indicator");
    chk_flow_latch: assert property (clk_en && sec_tick && pul_en[0] && !economy
        |=> flow_lat[0] == $past(win_cnt[0])) else $error("flow not latched");
    chk_active_time: assert property (clk_en && sec_tick && act[0] && bin_en[0]
        |=> act_sec[0] == $past(act_sec[0]) + 1'b1) else $error("active time lost");
    chk_unassigned: assert property (!chan_assigned[0]
        |=> !$rose(ev_pend[0]) && $stable(pulse_cnt[0])) else $error("unassigned input acted");
    chk_economy_count: assert property (economy && clk_en && pul_en[0] && rise[0]
        |=> pulse_cnt[0] != $past(pulse_cnt[0])) else $error("no count in economy");
endmodule

//--- tb/pbi_contacts.sv
// Purpose: Contacts or open-collector switches on the eight pins
// Assumes: Pins idle high through pull-ups; a closed switch grounds its pin
// Notes: glitch gives a short closure that the unit must ignore
`timescale 1ns/10ps
module pbi_contacts (
    input wire logic rst, // Async reset, active high
    input wire logic [pbi_pkg::NUM_IN-1:0] close, // Switch closed
    input wire logic [pbi_pkg::NUM_IN-1:0] glitch, // Bounce closure
    output logic [pbi_pkg::NUM_IN-1:0] pin_n // Pin level, low = grounded
);
    import pbi_pkg::*;
    // Pull-up holds pins high unless a switch grounds them
    assign pin_n = rst ? '1 : ~(close | glitch);
endmodule

//--- tb/pbi_unit_test.sv
// Purpose: Self-checking bench for the pulse/binary input unit
// Assumes: Debounce and second counts shortened by parameters
// Notes: Time is held loaded so event times are known
`timescale 1ns/10ps
module pbi_unit_test;
    import pbi_pkg::*;
    localparam int DEB = 4;
    localparam int SEC = 50;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [7:0] close = 8'h00, glitch = 8'h00, pin_n;
    logic [7:0] mode_pulse = 8'h06, chan_assigned = 8'h0B, alarm_delay_en = 8'h08;
    logic economy = 1'b0, store_weighted = 1'b0, time_load = 1'b1;
    logic [31:0] alarm_delay = 32'h0000_0002, store_interval = 32'h0000_0000;
    logic [31:0] time_set = 32'h0000_1234;
    logic [15:0] pulse_weight = 16'h0003;
    logic [2:0] rd_sel = 3'h0;
    logic [7:0] ind;
    logic event_valid, event_level, warn_valid, store_valid;
    logic [2:0] event_input, warn_input, store_input;
    logic [31:0] event_time, rd_count, rd_active_sec;
    logic [47:0] store_value, rd_flow, last_store;
    int err_count = 0, n_tests = 0, ev_cnt = 0, warn_cnt = 0, bad_store = 0, e0, w0;
    logic [2:0] last_in, last_warn;
    logic last_lvl;
    logic [31:0] last_time, a0;

    always #2 clock = ~clock;

    pbi_contacts sw_u (.rst(rst), .close(close), .glitch(glitch), .pin_n(pin_n));

    pbi_unit #(.DEB_CYCLES(DEB), .SEC_CYCLES(SEC)) dut_u (
        .clock(clock), .rst(rst), .clk_en(1'b1), .pin_n(pin_n), .mode_pulse(mode_pulse),
        .chan_assigned(chan_assigned), .alarm_delay_en(alarm_delay_en), .economy(economy),
        .alarm_delay(alarm_delay), .pulse_weight(pulse_weight),
        .store_interval(store_interval), .store_weighted(store_weighted),
        .time_load(time_load), .time_set(time_set), .rd_sel(rd_sel),
        .input_state_indicators(ind), .event_valid(event_valid), .event_input(event_input),
        .event_level(event_level), .event_time(event_time), .warn_valid(warn_valid),
        .warn_input(warn_input), .store_valid(store_valid), .store_input(store_input),
        .store_value(store_value), .rd_count(rd_count), .rd_active_sec(rd_active_sec),
        .rd_flow(rd_flow));

    // ----------------------------------------
    // Output monitors
    // ----------------------------------------
    always @(posedge clock) begin
        if (event_valid === 1'b1) begin
            ev_cnt++;
            last_in = event_input;
            last_lvl = event_level;
            last_time = event_time;
        end
        if (warn_valid === 1'b1) begin
            warn_cnt++;
            last_warn = warn_input;
        end
        if (store_valid === 1'b1) begin
            if (store_input === 3'h1) begin
                last_store = store_value;
            end else begin
                bad_store++;
            end
        end
    end

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic check(input logic [47:0] seen, input logic [47:0] exp, input string what);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask

    task automatic set_pin(input int idx, input logic v);
        @(posedge clock);
        close[idx] <= v;
    endtask

    task automatic pulses(input int idx, input int n);
        repeat (n) begin
            set_pin(idx, 1'b1);
            tick(4);
            set_pin(idx, 1'b0);
            tick(4);
        end
    endtask

    task automatic readout(input logic [2:0] sel);
        @(posedge clock);
        rd_sel <= sel;
        tick(3);
    endtask

    task automatic complete_run;
        if (err_count == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        tick(20000);
        err_count++;
        complete_run();
    end

    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        tick(12);
        rst <= 1'b0;
        tick(2);
        check(ind, 8'h00, "idle indicators");
        // Binary close and open of input 0
        set_pin(0, 1'b1);
        tick(DEB + 12);
        check(ind, 8'h01, "closed indicator");
        check(ev_cnt, 1, "close event count");
        check({last_in, last_lvl}, {3'h0, 1'b1}, "close event");
        check(last_time, 32'h0000_1234, "close event time");
        check(warn_cnt, 1, "close warning");
        set_pin(0, 1'b0);
        tick(DEB + 12);
        check(ind, 8'h00, "opened indicator");
        check({last_in, last_lvl}, {3'h0, 1'b0}, "open event");
        check(warn_cnt, 2, "open warning");
        // Short bounce is ignored
        @(posedge clock);
        glitch[0] <= 1'b1;
        tick(2);
        glitch[0] <= 1'b0;
        tick(DEB + 12);
        check(ev_cnt, 2, "bounce event");
        // Pulse input 1 and unassigned pulse input 2 together
        fork
            pulses(1, 7);
            pulses(2, 4);
        join
        tick(DEB + 10);
        readout(3'h1);
        check(rd_count, 32'h0000_0007, "pulse count");
        readout(3'h2);
        check(rd_count, 32'h0000_0000, "unassigned count");
        check(ev_cnt, 2, "pulse mode events");
        // Economy: counting goes on, binary events stop
        @(posedge clock);
        economy <= 1'b1;
        set_pin(0, 1'b1);
        pulses(1, 3);
        set_pin(0, 1'b0);
        tick(DEB + 10);
        readout(3'h1);
        check(rd_count, 32'h0000_000A, "economy count");
        check(ev_cnt, 2, "economy events");
        @(posedge clock);
        economy <= 1'b0;
        // Active time over about three seconds
        readout(3'h0);
        a0 = rd_active_sec;
        set_pin(0, 1'b1);
        tick(3 * SEC + 10);
        set_pin(0, 1'b0);
        tick(DEB + 10);
        readout(3'h0);
        check((rd_active_sec - a0) inside {[3:4]}, 1'b1, "active seconds");
        // Delayed warning on input 3
        w0 = warn_cnt;
        set_pin(3, 1'b1);
        tick(SEC - 20);
        set_pin(3, 1'b0);
        tick(DEB + 10);
        check(warn_cnt - w0, 0, "early warning");
        e0 = ev_cnt;
        set_pin(3, 1'b1);
        tick(4 * SEC);
        check(warn_cnt - w0, 1, "delayed warning");
        check(last_warn, 3'h3, "warning input");
        set_pin(3, 1'b0);
        tick(DEB + 10);
        check(ev_cnt - e0, 2, "delayed events");
        // Flow: five pulses per second window
        fork
            pulses(1, 30);
            begin
                tick(5 * SEC);
                readout(3'h1);
                check(rd_flow, 48'h0000_0000_000F, "flow");
            end
        join
        tick(DEB + 10);
        // Storing, raw then weighted
        @(posedge clock);
        store_interval <= 32'h0000_0001;
        tick(3 * SEC);
        check(last_store, 48'h0000_0000_0028, "raw record");
        @(posedge clock);
        store_weighted <= 1'b1;
        tick(3 * SEC);
        check(last_store, 48'h0000_0000_0078, "weighted record");
        check(bad_store, 0, "records of other inputs");
        complete_run();
    end
endmodule
